// >>> hdl/bcl_pkg.sv
package bcl_pkg;

    // ************************************************************
    // array geometry and register indices
    // ************************************************************
    localparam int BCL_BYTES = 4;                  // bytes in the latch array
    localparam int BCL_PORTS = 9;                  // ports with a reset drive field
    localparam int BCL_IDX_W = 3;                  // width of a register index
    localparam logic [2:0] BCL_IDX_PORT_LOW = 3'h0;  // port_drive_config_low
    localparam logic [2:0] BCL_IDX_PORT_HIGH = 3'h1; // port_drive_config_high
    localparam logic [2:0] BCL_IDX_RESET_DBG = 3'h2; // reset_pin_debug_config
    localparam logic [2:0] BCL_IDX_BOOT_ECC = 3'h3;  // boot_clock_ecc_config
    localparam logic [2:0] BCL_IDX_APPLIED = 3'h4;   // applied (latched) word, read only
    localparam logic [2:0] BCL_IDX_WEAR = 3'h5;      // array write count, read only
    localparam int BCL_IDX_LSB = 2;                // byte address is four times the index

    // ************************************************************
    // field layout within the 32-bit array word {b3,b2,b1,b0}
    // ************************************************************
    localparam int BCL_EXT_RESET_BIT = 23;         // byte 2 bit 7
    localparam int BCL_DEBUG_EN_BIT = 22;          // byte 2 bit 6
    localparam int BCL_PHASE_LSB = 28;             // byte 3 bits 7:4
    localparam int BCL_ECC_BIT = 27;               // byte 3 bit 3
    localparam int BCL_DPS_LSB = 25;               // byte 3 bits 2:1
    localparam int BCL_SPEED_BIT = 24;             // byte 3 bit 0
    localparam int BCL_PORT_LSB [BCL_PORTS] = '{0, 2, 4, 6, 8, 10, 12, 14, 16};

    // factory defaults: debug enabled, 4-wire jtag, ecc enabled, rest zero
    localparam logic [31:0] BCL_FACTORY_WORD = 32'h0a400000;
    // writable bits; byte 2 bits 5:2 are reserved and read as zero
    localparam logic [31:0] BCL_WRITE_MASK = 32'hffc3ffff;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        BCL_DRIVE_HIZ_ANALOG = 2'b00,
        BCL_DRIVE_HIZ_DIGITAL = 2'b01,
        BCL_DRIVE_PULL_UP = 2'b10,
        BCL_DRIVE_PULL_DOWN = 2'b11
    } bcl_drive_type;

    typedef enum logic [1:0] {
        BCL_DPS_JTAG5 = 2'b00,
        BCL_DPS_JTAG4 = 2'b01,
        BCL_DPS_SWD = 2'b10,
        BCL_DPS_NONE = 2'b11
    } bcl_dps_type;

    localparam logic [1:0] BCL_RESP_OKAY = 2'b00;
    localparam logic [1:0] BCL_RESP_SLVERR = 2'b10;
    localparam int BCL_WEAR_W = 16;                // saturating write counter width

endpackage

// >>> hdl/bcl_array_mem.sv
`timescale 1ns/100ps
module bcl_array_mem
    import bcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [1:0] wr_index,
    input wire logic [7:0] wr_byte,
    output logic [31:0] rd_word
);

    // ************************************************************
    // nonvolatile byte store
    // ************************************************************
    // no reset here on purpose: the contents must survive every reset
    logic [7:0] cell_reg [BCL_BYTES];
    logic [31:0] rd_word_reg;

    // factory image, standing in for the erased state of the cells
    initial begin
        for (int i = 0; i < BCL_BYTES; i++) begin
            cell_reg[i] = BCL_FACTORY_WORD[8*i +: 8];
        end
    end

    // byte write from the programming side
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            cell_reg[wr_index] <= wr_byte;
        end
    end

    // whole word mirrored into a register every cycle
    always_ff @(posedge core_clk) begin
        rd_word_reg <= {cell_reg[3], cell_reg[2], cell_reg[1], cell_reg[0]};
    end

    assign rd_word = rd_word_reg;

endmodule

// >>> hdl/bcl_pin_sync.sv
`timescale 1ns/100ps
module bcl_pin_sync
    import bcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_out
);

    // ************************************************************
    // three-stage pin synchroniser with agreement filter
    // ************************************************************
    logic meta_reg;    // first stage, read only by the second
    logic sync_reg;    // second stage
    logic hold_reg;    // third stage
    logic level_reg;   // accepted level

    // idle level of an active-low pin is high
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            hold_reg <= 1'b1;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            hold_reg <= sync_reg;
        end
    end

    // a change counts only once second and third stages agree
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            level_reg <= 1'b1;
        end else if (sync_reg == hold_reg) begin
            level_reg <= hold_reg;
        end
    end

    assign level_out = level_reg;

endmodule

// >>> hdl/bcl_boot_config_latches.sv
`timescale 1ns/100ps
module bcl_boot_config_latches
    import bcl_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic core_clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // shared pin when used as reset, active low
    input wire logic ext_reset_pin_n,
    // applied configuration
    output logic [2*BCL_PORTS-1:0] port_reset_drive_field,
    output logic ext_reset_pin_select,
    output logic ext_reset_request,
    output logic debug_access_enable,
    output logic boot_clock_speed,
    output logic [1:0] debug_port_select,
    output logic [2:0] debug_port_onehot,
    output logic flash_ecc_enable,
    output logic [3:0] digital_clock_phase_delay
);

    // ************************************************************
    // state types and declarations
    // ************************************************************
    typedef enum logic [1:0] {
        BCL_RD_IDLE = 2'b00,
        BCL_RD_FETCH = 2'b01,
        BCL_RD_ANSWER = 2'b10
    } bcl_rd_state_type;

    typedef enum logic [0:0] {
        BCL_WR_COLLECT = 1'b0,
        BCL_WR_RESP = 1'b1
    } bcl_wr_state_type;

    bcl_rd_state_type rd_state_reg;   // read channel state
    bcl_rd_state_type rd_state_next;
    bcl_wr_state_type wr_state_reg;   // write channel state
    bcl_wr_state_type wr_state_next;

    logic awready_reg;                // address slot free
    logic wready_reg;                 // data slot free
    logic have_aw_reg;                // write address held
    logic have_w_reg;                 // write data held
    logic [ADDR_W-1:0] waddr_reg;     // held write address
    logic [31:0] wdata_reg;           // held write data
    logic [3:0] wstrb_reg;            // held byte strobes
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    logic arready_reg;
    logic [ADDR_W-1:0] raddr_reg;     // held read address
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic [31:0] array_word;          // registered mirror of the array
    logic [31:0] latch_reg;           // configuration applied at reset
    logic [BCL_WEAR_W-1:0] wear_reg;  // array writes landed since reset
    logic ext_req_reg;                // qualified external reset request
    logic [2:0] dps_onehot_reg;       // decoded debug port
    logic pin_level;                  // filtered pin level

    // ************************************************************
    // address decode
    // ************************************************************
    // index sits at bits 4:2, anything above must be zero
    wire [BCL_IDX_W-1:0] wr_idx = waddr_reg[BCL_IDX_LSB +: BCL_IDX_W];
    wire [BCL_IDX_W-1:0] rd_idx = raddr_reg[BCL_IDX_LSB +: BCL_IDX_W];
    wire wr_high_zero = (waddr_reg >> (BCL_IDX_LSB + BCL_IDX_W)) == '0;
    wire rd_high_zero = (raddr_reg >> (BCL_IDX_LSB + BCL_IDX_W)) == '0;
    wire wr_is_array = wr_high_zero && (wr_idx <= BCL_IDX_BOOT_ECC);
    wire rd_is_array = rd_high_zero && (rd_idx <= BCL_IDX_BOOT_ECC);
    wire rd_is_applied = rd_high_zero && (rd_idx == BCL_IDX_APPLIED);
    wire rd_is_wear = rd_high_zero && (rd_idx == BCL_IDX_WEAR);
    wire rd_known = rd_is_array || rd_is_applied || rd_is_wear;

    // ************************************************************
    // write path
    // ************************************************************
    wire aw_take = s_axi_awvalid && awready_reg;
    wire w_take = s_axi_wvalid && wready_reg;
    wire wr_fire = (wr_state_reg == BCL_WR_COLLECT) && have_aw_reg && have_w_reg;
    // a write lands only when lane 0 is strobed; the data sits in the low byte
    wire mem_we = wr_fire && wr_is_array && wstrb_reg[0];
    wire [1:0] mem_index = wr_idx[1:0];
    // reserved bits never reach the cells, so they always read as zero
    wire [7:0] mem_mask = BCL_WRITE_MASK[8*mem_index +: 8];
    wire [7:0] mem_byte = wdata_reg[7:0] & mem_mask;
    wire wr_done = bvalid_reg && s_axi_bready;

    // write sequencing
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            BCL_WR_COLLECT: begin
                if (wr_fire) begin
                    wr_state_next = BCL_WR_RESP;
                end
            end
            BCL_WR_RESP: begin
                if (wr_done) begin
                    wr_state_next = BCL_WR_COLLECT;
                end
            end
            default: wr_state_next = BCL_WR_COLLECT;
        endcase
    end

    // address and data slots fill in either order
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            awready_reg <= 1'b1;
            have_aw_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (aw_take) begin
            awready_reg <= 1'b0;
            have_aw_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
        end else if (wr_done) begin
            awready_reg <= 1'b1;
            have_aw_reg <= 1'b0;
        end
    end

    // data slot
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wready_reg <= 1'b1;
            have_w_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (w_take) begin
            wready_reg <= 1'b0;
            have_w_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_done) begin
            wready_reg <= 1'b1;
            have_w_reg <= 1'b0;
        end
    end

    // response, error for read-only or unmapped targets
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_state_reg <= BCL_WR_COLLECT;
            bvalid_reg <= 1'b0;
            bresp_reg <= BCL_RESP_OKAY;
        end else begin
            wr_state_reg <= wr_state_next;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_is_array ? BCL_RESP_OKAY : BCL_RESP_SLVERR;
            end else if (wr_done) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // wear count
    // each landed write up to the 65535th is counted so software can watch cell wear;
    // the count is volatile and restarts at every reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wear_reg <= '0;
        end else if (mem_we && (wear_reg != '1)) begin
            wear_reg <= wear_reg + 1'b1;
        end
    end

    // ************************************************************
    // nonvolatile array
    // ************************************************************
    // four-byte store
    bcl_array_mem u_array (
        .core_clk(core_clk),
        .wr_en(mem_we),
        .wr_index(mem_index),
        .wr_byte(mem_byte),
        .rd_word(array_word)
    );

    // ************************************************************
    // read path
    // ************************************************************
    wire ar_take = s_axi_arvalid && arready_reg;
    wire rd_done = rvalid_reg && s_axi_rready;
    // read data selection; the array reads its live contents
    wire [31:0] rd_array_byte = {24'h000000, array_word[8*rd_idx[1:0] +: 8]};
    wire [31:0] rd_wear_word = {{(32-BCL_WEAR_W){1'b0}}, wear_reg};
    wire [31:0] rd_mux = rd_is_array ? rd_array_byte :
                         rd_is_applied ? latch_reg :
                         rd_is_wear ? rd_wear_word : 32'h00000000;

    // read sequencing
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            BCL_RD_IDLE: begin
                if (ar_take) begin
                    rd_state_next = BCL_RD_FETCH;
                end
            end
            BCL_RD_FETCH: rd_state_next = BCL_RD_ANSWER;
            BCL_RD_ANSWER: begin
                if (rd_done) begin
                    rd_state_next = BCL_RD_IDLE;
                end
            end
            default: rd_state_next = BCL_RD_IDLE;
        endcase
    end

    // the fetch cycle lets a write just landed show in the mirror
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rd_state_reg <= BCL_RD_IDLE;
            arready_reg <= 1'b1;
            raddr_reg <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= BCL_RESP_OKAY;
        end else begin
            rd_state_reg <= rd_state_next;
            if (ar_take) begin
                arready_reg <= 1'b0;
                raddr_reg <= s_axi_araddr;
            end
            if (rd_state_reg == BCL_RD_FETCH) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_known ? BCL_RESP_OKAY : BCL_RESP_SLVERR;
            end else if (rd_done) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // configuration capture
    // ************************************************************
    // capture during reset
    // no asynchronous reset: the flops follow the array on every edge
    // while reset is high and freeze at release, so later programming
    // only takes effect at the next reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            latch_reg <= array_word;
        end
    end

    // ************************************************************
    // derived outputs
    // ************************************************************
    // debug port decode
    // one-hot: bit 0 jtag5, bit 1 jtag4, bit 2 swd; none when no access
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dps_onehot_reg <= 3'h0;
        end else if (!latch_reg[BCL_DEBUG_EN_BIT]) begin
            dps_onehot_reg <= 3'h0;
        end else begin
            case (bcl_dps_type'(latch_reg[BCL_DPS_LSB +: 2]))
                BCL_DPS_JTAG5: dps_onehot_reg <= 3'h1;
                BCL_DPS_JTAG4: dps_onehot_reg <= 3'h2;
                BCL_DPS_SWD: dps_onehot_reg <= 3'h4;
                default: dps_onehot_reg <= 3'h0;
            endcase
        end
    end

    bcl_pin_sync u_pin_sync (
        .core_clk(core_clk),
        .reset(reset),
        .pin_in(ext_reset_pin_n),
        .level_out(pin_level)
    );

    // the pin asks for reset only when the latch hands it that role
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ext_req_reg <= 1'b0;
        end else begin
            ext_req_reg <= latch_reg[BCL_EXT_RESET_BIT] && !pin_level;
        end
    end

    // per-port drive field
    // one field per port drives all its pins; no per-pin choice exists
    genvar gp;
    generate
        for (gp = 0; gp < BCL_PORTS; gp++) begin : g_port
            assign port_reset_drive_field[2*gp +: 2] = latch_reg[BCL_PORT_LSB[gp] +: 2];
        end
    endgenerate

    assign ext_reset_pin_select = latch_reg[BCL_EXT_RESET_BIT];
    assign debug_access_enable = latch_reg[BCL_DEBUG_EN_BIT];
    assign boot_clock_speed = latch_reg[BCL_SPEED_BIT];
    assign debug_port_select = latch_reg[BCL_DPS_LSB +: 2];
    assign flash_ecc_enable = latch_reg[BCL_ECC_BIT];
    assign digital_clock_phase_delay = latch_reg[BCL_PHASE_LSB +: 4];
    assign debug_port_onehot = dps_onehot_reg;
    assign ext_reset_request = ext_req_reg;

    // ************************************************************
    // bus outputs
    // ************************************************************
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

endmodule

// >>> tb/bcl_chk.sv
`timescale 1ns/100ps
module bcl_chk
    import bcl_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_reset_pin_n,
    input wire logic [2*BCL_PORTS-1:0] port_reset_drive_field,
    input wire logic ext_reset_pin_select,
    input wire logic ext_reset_request,
    input wire logic debug_access_enable,
    input wire logic [1:0] debug_port_select,
    input wire logic [2:0] debug_port_onehot
);
    // ************************************************************
    // helpers
    // ************************************************************
    // applied fields watched for stability
    wire [21:0] cfg = {port_reset_drive_field, ext_reset_pin_select, debug_access_enable,
        debug_port_select};
    // one-hot expected; none if debug off or no port
    wire [2:0] oh_exp = (debug_access_enable && debug_port_select != 2'b11) ?
        (3'h1 << debug_port_select) : 3'h0;
    wire sel_low = ext_reset_pin_select && !ext_reset_pin_n;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ************************************************************
    // assertions
    // ************************************************************
    // held after reset
    cfg_hold_a: assert property (!$past(reset) |-> $stable(cfg))
        else $error("config changed outside reset");
    port_decode_a: assert property (!$past(reset) |-> debug_port_onehot == oh_exp)
        else $error("debug port one-hot wrong");
    xreq_on_a: assert property (sel_low [*6] |=> ext_reset_request)
        else $error("external reset not requested");
    xreq_off_a: assert property (!sel_low [*6] |=> !ext_reset_request)
        else $error("spurious external reset request");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read data late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
        $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    unmap_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] > 3'h5
        |-> ##[1:3] (s_axi_rvalid && s_axi_rresp == BCL_RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    // main scenarios reached
    cov_swd: cover property (debug_port_onehot == 3'b100);
    cov_xreq: cover property (ext_reset_request);
    cov_err: cover property (s_axi_rvalid && s_axi_rresp == BCL_RESP_SLVERR);
endmodule
bind bcl_boot_config_latches bcl_chk #(.ADDR_W(ADDR_W)) chk (.*);

// >>> tb/bcl_prog_model.sv
`timescale 1ns/100ps
module bcl_prog_model (
    input wire logic core_clk,
    output logic [7:0] s_axi_awaddr,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_awvalid,
    output logic s_axi_wvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    output logic s_axi_rready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    int lag = 0; // cycles before accepting the answer
    // idle bus from time zero
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // one write per byte
    // writes only on request; each one that lands in the array wears it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        int n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
            if (n >= lag && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // word read; address held until taken
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
            if (n >= lag && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// >>> tb/boot_config_latches_bench.sv
`timescale 1ns/100ps
module boot_config_latches_bench;
    import bcl_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_pin_n = 1'b1;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire [17:0] port_reset_drive_field;
    wire [1:0] debug_port_select;
    wire [2:0] debug_port_onehot;
    wire [3:0] digital_clock_phase_delay;
    wire ext_reset_pin_select, ext_reset_request, debug_access_enable, boot_clock_speed;
    wire flash_ecc_enable;
    int error_cnt = 0;
    int total_checks = 0;
    logic [1:0] resp;
    logic [31:0] rd_data, word, prev;
    // rows: array words {b3,b2,b1,b0}, reserved bits set in the first two
    logic [31:0] rows [4] = '{32'hf9fe1be4, 32'h523d55aa, 32'hac4300ff, 32'h37409c36};
    // every applied output except ext_reset_request in one word
    wire [31:0] cfg_seen = {1'b0, port_reset_drive_field, ext_reset_pin_select,
        debug_access_enable, boot_clock_speed, debug_port_select, flash_ecc_enable,
        digital_clock_phase_delay, debug_port_onehot};
    always #25 core_clk = ~core_clk;
    bcl_boot_config_latches dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));
    bcl_prog_model prog (.*);
    // ************************************************************
    // helpers
    // ************************************************************
    // outputs expected from a stored word
    function automatic logic [31:0] exp_cfg(input logic [31:0] w);
        logic [2:0] oh;
        oh = (w[22] && w[26:25] != 2'b11) ? (3'h1 << w[26:25]) : 3'h0;
        return {1'b0, w[17:0], w[23], w[22], w[24], w[26:25], w[27], w[31:28], oh};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // capture reset, then let the decode settle
    task automatic pulse_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        prev = 32'h0a400000;
        check(cfg_seen, exp_cfg(prev));
        for (int i = 0; i < 4; i++) begin
            word = rows[i] & BCL_WRITE_MASK;
            prog.lag = i;
            for (int b = 0; b < 4; b++) begin
                prog.wr(8'(4 * b), {24'h0, rows[i][8*b +: 8]}, 4'hf, resp);
                check({30'h0, resp}, {30'h0, BCL_RESP_OKAY});
            end
            for (int b = 0; b < 4; b++) begin
                prog.rd(8'(4 * b), rd_data, resp);
                check(rd_data, {24'h0, word[8*b +: 8]});
            end
            prog.rd(8'h14, rd_data, resp);
            check(rd_data, 32'h4);
            check(cfg_seen, exp_cfg(prev));
            pulse_reset();
            check(cfg_seen, exp_cfg(word));
            prog.rd(8'h10, rd_data, resp);
            check(rd_data, word);
            prev = word;
        end
        // pin selected as external reset: request follows the pin
        prog.wr(8'h08, 32'hc0, 4'hf, resp);
        pulse_reset();
        ext_reset_pin_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        check({31'h0, ext_reset_request}, 32'h1);
        ext_reset_pin_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        check({31'h0, ext_reset_request}, 32'h0);
        // refused places and a write with no byte lane
        prog.rd(8'h18, rd_data, resp);
        check(rd_data, 32'h0);
        check({30'h0, resp}, {30'h0, BCL_RESP_SLVERR});
        prog.wr(8'h10, 32'hff, 4'hf, resp);
        check({30'h0, resp}, {30'h0, BCL_RESP_SLVERR});
        prog.wr(8'h0c, 32'h55, 4'h0, resp);
        prog.rd(8'h0c, rd_data, resp);
        check(rd_data, {24'h0, prev[31:24]});
        finish_test();
    end
    // hang guard, far beyond the test length
    initial begin
        repeat (4000) @(posedge core_clk);
        error_cnt++;
        finish_test();
    end
endmodule
